// File: include/pixel_clock_pkg.sv
package pixel_clock_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register indices on the plain port
    localparam logic [ADDR_W-1:0] VIDEO_CTRL_ADDR   = 4'h0;
    localparam logic [ADDR_W-1:0] PLL_DIV_CTRL_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] PLL_STATUS_ADDR   = 4'h2;

    // reset values
    localparam logic [DATA_W-1:0] VIDEO_CTRL_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0] PLL_DIV_CTRL_RESET = 16'h0000;

    // video control word fields
    localparam int PIX_SEL_LSB   = 0;
    localparam int PIX_SEL_W     = 2;
    localparam int PRESCALE_LSB  = 2;
    localparam int PRESCALE_W    = 3;
    localparam int SOUND_SEL_BIT = 5;

    // pixel source select codes
    localparam logic [PIX_SEL_W-1:0] PIX_SRC_HIGH = 2'h0;
    localparam logic [PIX_SEL_W-1:0] PIX_SRC_VCO  = 2'h1;
    localparam logic [PIX_SEL_W-1:0] PIX_SRC_REF  = 2'h2;

    // divider control fields
    localparam int MOD_W          = 6;
    localparam int REF_MOD_LSB    = 0;
    localparam int FORCE_HIGH_BIT = 6;
    localparam int CLEAR_REF_BIT  = 7;
    localparam int VCO_MOD_LSB    = 8;
    localparam int FORCE_LOW_BIT  = 14;
    localparam int CLEAR_VCO_BIT  = 15;

    // synchronised inputs, one bit each
    localparam int SYNC_W   = 4;
    localparam int IN_HIGH  = 0;
    localparam int IN_VCO   = 1;
    localparam int IN_IO    = 2;
    localparam int IN_SOUND = 3;

    // phase detector states
    typedef enum logic [1:0] {
        PFD_IDLE = 2'b00,
        PFD_UP   = 2'b01,
        PFD_DOWN = 2'b10
    } pfd_state_e;

endpackage

// File: src/pixel_clock_pll_control.sv
`timescale 1ns/10ps

// Summary of operation
// - pixel source picked by the two lowest video control bits.
// - three-bit prescaler divides the chosen pixel clock by 1 to 8.
// - candidates are high clock, vco clock and internal 32 MHz reference.
// - only vco clock and reference feed the phase comparator.
// - sound clock from reference or sound input, halved internally.
// - two preloadable down counters, on reference and vco, plus detector.
// - bit 6 forces phase output high unless bit 14 is set; bit 14 forces it low.
// - bit 7 holds reference counter clear, bit 15 the vco counter.
// - phase output floats normally; high speeds vco up, low slows it.
// - locked vco is reference times vco modulus over ref modulus.
// - modulus fields hold modulus minus one; counters divide by modulus.
// - one correction per counter cycle; small moduli update more often.
module pixel_clock_pll_control
    import pixel_clock_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              high_clock_in,
    input  wire logic              vco_clock_in,
    input  wire logic              io_clock_in,
    input  wire logic              sound_clock_in,
    output logic                   pixel_clock_out,
    output logic                   sound_clock_out,
    output logic                   internal_ref_clock_32,
    output logic                   phase_error_out,
    output logic                   phase_error_oe_n
);

    logic [DATA_W-1:0] video_ctrl_reg;
    logic [DATA_W-1:0] video_ctrl_next;
    logic [DATA_W-1:0] pll_ctrl_reg;
    logic [DATA_W-1:0] pll_ctrl_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] rise;

    logic [MOD_W-1:0]  ref_cnt_reg;
    logic [MOD_W-1:0]  ref_cnt_next;
    logic [MOD_W-1:0]  vco_cnt_reg;
    logic [MOD_W-1:0]  vco_cnt_next;
    pfd_state_e        pfd_reg;
    pfd_state_e        pfd_next;
    logic              pe_out_reg;
    logic              pe_out_next;
    logic              pe_oe_n_reg;
    logic              pe_oe_n_next;

    logic [PRESCALE_W-1:0] pix_cnt_reg;
    logic [PRESCALE_W-1:0] pix_cnt_next;
    logic              pix_out_reg;
    logic              pix_out_next;
    logic              snd_out_reg;
    logic              snd_out_next;
    logic              ref_out_reg;

    logic [PIX_SEL_W-1:0]  pix_sel;
    logic [PRESCALE_W-1:0] prescale;
    logic [PRESCALE_W-1:0] high_count;
    logic              src_level;
    logic              src_rise;
    logic              snd_rise;
    logic [MOD_W-1:0]  ref_mod;
    logic [MOD_W-1:0]  vco_mod;
    logic              force_high;
    logic              force_low;
    logic              clear_ref;
    logic              clear_vco;
    logic              ref_term;
    logic              vco_term;

    // field decode
    assign pix_sel    = video_ctrl_reg[PIX_SEL_LSB +: PIX_SEL_W];
    assign prescale   = video_ctrl_reg[PRESCALE_LSB +: PRESCALE_W];
    assign ref_mod    = pll_ctrl_reg[REF_MOD_LSB +: MOD_W];
    assign vco_mod    = pll_ctrl_reg[VCO_MOD_LSB +: MOD_W];
    assign force_high = pll_ctrl_reg[FORCE_HIGH_BIT];
    assign force_low  = pll_ctrl_reg[FORCE_LOW_BIT];
    assign clear_ref  = pll_ctrl_reg[CLEAR_REF_BIT];
    assign clear_vco  = pll_ctrl_reg[CLEAR_VCO_BIT];

    // rising edges seen after the two-flop synchronisers
    assign rise = sync2_reg & ~sync3_reg;

    // terminal events of the two moduli counters
    assign ref_term = rise[IN_IO] && !clear_ref
                      && (ref_cnt_reg == '0);
    assign vco_term = rise[IN_VCO] && !clear_vco
                      && (vco_cnt_reg == '0);

    // source mux and prescaler counts
    always_comb begin
        case (pix_sel)
            PIX_SRC_HIGH: begin
                src_level = sync2_reg[IN_HIGH];
                src_rise  = rise[IN_HIGH];
            end
            PIX_SRC_VCO: begin
                src_level = sync2_reg[IN_VCO];
                src_rise  = rise[IN_VCO];
            end
            PIX_SRC_REF: begin
                src_level = sync2_reg[IN_IO];
                src_rise  = rise[IN_IO];
            end
            default: begin
                src_level = sync2_reg[IN_IO];
                src_rise  = rise[IN_IO];
            end
        endcase
        high_count = PRESCALE_W'((PRESCALE_W + 1)'(prescale) + 1'b1 >> 1);
        snd_rise = video_ctrl_reg[SOUND_SEL_BIT] ? rise[IN_SOUND]
                                                  : rise[IN_IO];
    end

    // register port next state
    always_comb begin
        video_ctrl_next = video_ctrl_reg;
        pll_ctrl_next   = pll_ctrl_reg;
        rdata_next      = '0;
        if (wr) begin
            if (addr == VIDEO_CTRL_ADDR) begin
                video_ctrl_next = wdata;
            end
            if (addr == PLL_DIV_CTRL_ADDR) begin
                pll_ctrl_next = wdata;
            end
        end
        if (rd) begin
            case (addr)
                VIDEO_CTRL_ADDR:   rdata_next = video_ctrl_reg;
                PLL_DIV_CTRL_ADDR: rdata_next = pll_ctrl_reg;
                PLL_STATUS_ADDR:   rdata_next = {vco_cnt_reg, ref_cnt_reg,
                                                 pe_oe_n_reg, pe_out_reg,
                                                 pfd_reg};
                default:           rdata_next = '0;
            endcase
        end
    end

    // clock generation next state
    always_comb begin
        pix_cnt_next = pix_cnt_reg;
        if (src_rise) begin
            if (pix_cnt_reg >= prescale) begin
                pix_cnt_next = '0;
            end else begin
                pix_cnt_next = pix_cnt_reg + 1'b1;
            end
        end
        if (prescale == '0) begin
            pix_out_next = src_level;
        end else begin
            pix_out_next = (pix_cnt_next < high_count);
        end
        snd_out_next = snd_rise ? !snd_out_reg : snd_out_reg;
    end

    // comparator next state
    always_comb begin
        ref_cnt_next = ref_cnt_reg;
        vco_cnt_next = vco_cnt_reg;
        if (clear_ref) begin
            ref_cnt_next = '0;
        end else if (rise[IN_IO]) begin
            ref_cnt_next = (ref_cnt_reg == '0) ? ref_mod
                         : ref_cnt_reg - 1'b1;
        end
        if (clear_vco) begin
            vco_cnt_next = '0;
        end else if (rise[IN_VCO]) begin
            vco_cnt_next = (vco_cnt_reg == '0) ? vco_mod
                         : vco_cnt_reg - 1'b1;
        end

        // one correction per counter cycle
        case (pfd_reg)
            PFD_IDLE: begin
                if (ref_term && !vco_term) begin
                    pfd_next = PFD_UP;
                end else if (vco_term && !ref_term) begin
                    pfd_next = PFD_DOWN;
                end else begin
                    pfd_next = PFD_IDLE;
                end
            end
            PFD_UP:   pfd_next = vco_term ? PFD_IDLE : PFD_UP;
            PFD_DOWN: pfd_next = ref_term ? PFD_IDLE : PFD_DOWN;
            default:  pfd_next = PFD_IDLE;
        endcase

        if (force_low) begin
            pe_out_next  = 1'b0;
            pe_oe_n_next = 1'b0;
        end else if (force_high) begin
            pe_out_next  = 1'b1;
            pe_oe_n_next = 1'b0;
        end else if (pfd_next == PFD_UP) begin
            pe_out_next  = 1'b1;
            pe_oe_n_next = 1'b0;
        end else if (pfd_next == PFD_DOWN) begin
            pe_out_next  = 1'b0;
            pe_oe_n_next = 1'b0;
        end else begin
            pe_out_next  = 1'b0;
            pe_oe_n_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg      <= '0;
            sync2_reg      <= '0;
            sync3_reg      <= '0;
            video_ctrl_reg <= VIDEO_CTRL_RESET;
            pll_ctrl_reg   <= PLL_DIV_CTRL_RESET;
            rdata_reg      <= '0;
            ref_cnt_reg    <= '0;
            vco_cnt_reg    <= '0;
            pfd_reg        <= PFD_IDLE;
            pe_out_reg     <= 1'b0;
            pe_oe_n_reg    <= 1'b1;
            pix_cnt_reg    <= '0;
            pix_out_reg    <= 1'b0;
            snd_out_reg    <= 1'b0;
            ref_out_reg    <= 1'b0;
        end else begin
            sync1_reg      <= {sound_clock_in, io_clock_in,
                               vco_clock_in, high_clock_in};
            sync2_reg      <= sync1_reg;
            sync3_reg      <= sync2_reg;
            video_ctrl_reg <= video_ctrl_next;
            pll_ctrl_reg   <= pll_ctrl_next;
            rdata_reg      <= rdata_next;
            ref_cnt_reg    <= ref_cnt_next;
            vco_cnt_reg    <= vco_cnt_next;
            pfd_reg        <= pfd_next;
            pe_out_reg     <= pe_out_next;
            pe_oe_n_reg    <= pe_oe_n_next;
            pix_cnt_reg    <= pix_cnt_next;
            pix_out_reg    <= pix_out_next;
            snd_out_reg    <= snd_out_next;
            ref_out_reg    <= sync2_reg[IN_IO];
        end
    end

    assign rdata                 = rdata_reg;
    assign pixel_clock_out       = pix_out_reg;
    assign sound_clock_out       = snd_out_reg;
    assign internal_ref_clock_32 = ref_out_reg;
    assign phase_error_out       = pe_out_reg;
    assign phase_error_oe_n      = pe_oe_n_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_force_low_wins: assert property (
        force_low |=> !phase_error_out && !phase_error_oe_n)
        else $error("force low not driving phase output low");

    a_force_high_drive: assert property (
        force_high && !force_low |=> phase_error_out && !phase_error_oe_n)
        else $error("force high not driving phase output high");

    a_ref_clear_hold: assert property (
        clear_ref |=> ref_cnt_reg == '0)
        else $error("reference counter not held clear");

    a_vco_clear_hold: assert property (
        clear_vco ##1 clear_vco |-> vco_cnt_reg == '0 && !vco_term)
        else $error("vco counter not held clear");

    a_idle_float: assert property (
        !force_low && !force_high && pfd_next == PFD_IDLE
        |=> phase_error_oe_n)
        else $error("phase output driven while idle");

    a_ref_first_up: assert property (
        pfd_reg == PFD_IDLE && ref_term && !vco_term && !force_low
        && !force_high |=> phase_error_out && !phase_error_oe_n
        && pfd_reg == PFD_UP)
        else $error("reference lead not giving speed-up drive");

    a_ref_reload: assert property (
        rise[IN_IO] && !clear_ref && ref_cnt_reg == '0 && !wr
        |=> ref_cnt_reg == $past(ref_mod))
        else $error("reference counter not reloaded with modulus");

    a_ref_count_down: assert property (
        rise[IN_IO] && !clear_ref && ref_cnt_reg != '0
        |=> ref_cnt_reg == $past(ref_cnt_reg) - 1'b1)
        else $error("reference counter not decrementing");

    a_prescale_wrap: assert property (
        src_rise && pix_cnt_reg == prescale |=> pix_cnt_reg == '0)
        else $error("prescaler not wrapping at setting");

    a_read_data: assert property (
        rd && addr == VIDEO_CTRL_ADDR && !wr
        |=> rdata == $past(video_ctrl_reg))
        else $error("control word read back wrong");

    c_speed_up: cover property (pfd_reg == PFD_UP ##1 pfd_reg == PFD_IDLE);
    c_slow_down: cover property (pfd_reg == PFD_DOWN);
    c_startup_force: cover property (force_low && clear_ref && clear_vco);
    c_prescale_wrap: cover property (src_rise && prescale != '0
                                     && pix_cnt_reg == prescale);

endmodule // pixel_clock_pll_control

// File: verification/vco_filter_model.sv
`timescale 1ns/10ps

// loop filter plus vco: driven high shortens the period, driven low
// lengthens it, floating leaves the integrator alone
module vco_filter_model #(
    parameter real START_NS = 60.0,
    parameter real STEP_NS  = 0.02
) (
    input  wire logic phase_error_out,
    input  wire logic phase_error_oe_n,
    output logic      vco_clock_in
);
    real integ_ns = START_NS;
    real half_ns;

    // integrating path, clamped to what the sampled input can follow
    initial begin
        forever begin
            #10;
            if (phase_error_oe_n === 1'b0)
                integ_ns += phase_error_out ? -STEP_NS : STEP_NS;
            if (integ_ns < 40.0)
                integ_ns = 40.0;
            if (integ_ns > 200.0)
                integ_ns = 200.0;
        end
    end

    // proportional kick on top of the integrator
    initial begin
        vco_clock_in = 1'b0;
        forever begin
            half_ns = integ_ns / 2.0;
            if (phase_error_oe_n === 1'b0)
                half_ns += phase_error_out ? -2.0 : 2.0;
            #(half_ns) vco_clock_in = ~vco_clock_in;
        end
    end
endmodule // vco_filter_model

// File: verification/tb_pixel_clock_pll_control.sv
`timescale 1ns/10ps

module tb_pixel_clock_pll_control;
    import pixel_clock_pkg::*;

    logic              clk            = 1'b0;
    logic              nrst           = 1'b0;
    logic [ADDR_W-1:0] addr           = '0;
    logic [DATA_W-1:0] wdata          = '0;
    logic              wr             = 1'b0;
    logic              rd             = 1'b0;
    logic              high_clock_in  = 1'b0;
    logic              io_clock_in    = 1'b0;
    logic              sound_clock_in = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              vco_clock_in;
    logic              pixel_clock_out;
    logic              sound_clock_out;
    logic              internal_ref_clock_32;
    logic              phase_error_out;
    logic              phase_error_oe_n;
    int                err_total = 0;
    int                cmp_count = 0;
    int                cycles    = 0;
    // edges: 0 high, 1 vco, 2 io, 3 sound in, 4 pixel, 5 sound out, 6 ref
    int                n [7] = '{default: 0};
    int                dn [7];
    logic [DATA_W-1:0] pe_word;

    assign pe_word = {14'h0, phase_error_oe_n, phase_error_out};

    initial begin
        forever #4 clk = ~clk;
    end
    initial forever #24 high_clock_in = ~high_clock_in;
    initial forever #15.625 io_clock_in = ~io_clock_in;
    initial forever #31.25 sound_clock_in = ~sound_clock_in;

    always @(posedge high_clock_in) n[0]++;
    always @(posedge vco_clock_in) n[1]++;
    always @(posedge io_clock_in) n[2]++;
    always @(posedge sound_clock_in) n[3]++;
    always @(posedge pixel_clock_out) n[4]++;
    always @(posedge sound_clock_out) n[5]++;
    always @(posedge internal_ref_clock_32) n[6]++;

    pixel_clock_pll_control u_pixel_clock_pll_control (
        .clk                   (clk),
        .nrst                  (nrst),
        .addr                  (addr),
        .wdata                 (wdata),
        .wr                    (wr),
        .rd                    (rd),
        .rdata                 (rdata),
        .high_clock_in         (high_clock_in),
        .vco_clock_in          (vco_clock_in),
        .io_clock_in           (io_clock_in),
        .sound_clock_in        (sound_clock_in),
        .pixel_clock_out       (pixel_clock_out),
        .sound_clock_out       (sound_clock_out),
        .internal_ref_clock_32 (internal_ref_clock_32),
        .phase_error_out       (phase_error_out),
        .phase_error_oe_n      (phase_error_oe_n)
    );

    vco_filter_model #(.START_NS(60.0), .STEP_NS(0.02)) u_vco_filter_model (
        .phase_error_out  (phase_error_out),
        .phase_error_oe_n (phase_error_oe_n),
        .vco_clock_in     (vco_clock_in)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic cmp_val(input logic [DATA_W-1:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_rate(input int got, lo, hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic bus_write(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic bus_read(input logic [ADDR_W-1:0] a,
                            output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic window(input int cyc);
        int s [7];
        s = n;
        repeat (cyc) @(posedge clk);
        foreach (dn[i]) dn[i] = n[i] - s[i];
    endtask

    task automatic test_regs();
        logic [DATA_W-1:0] d;
        bus_read(VIDEO_CTRL_ADDR, d);
        cmp_val(d, VIDEO_CTRL_RESET);
        bus_read(PLL_DIV_CTRL_ADDR, d);
        cmp_val(d, PLL_DIV_CTRL_RESET);
        bus_write(VIDEO_CTRL_ADDR, 16'h0025);
        bus_write(4'h9, 16'hFFFF);
        bus_write(PLL_STATUS_ADDR, 16'hFFFF);
        bus_read(VIDEO_CTRL_ADDR, d);
        cmp_val(d, 16'h0025);
        @(posedge clk);
        #1 cmp_val(rdata, 16'h0000);
        bus_read(4'hF, d);
        cmp_val(d, 16'h0000);
        bus_read(PLL_DIV_CTRL_ADDR, d);
        cmp_val(d, PLL_DIV_CTRL_RESET);
        $display("test regs done");
    endtask

    task automatic test_force();
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] s;
        bus_write(PLL_DIV_CTRL_ADDR, 16'h80C0);
        @(posedge clk);
        #1 cmp_val(pe_word, 16'h0001);
        bus_write(PLL_DIV_CTRL_ADDR, 16'hC080);
        @(posedge clk);
        #1 cmp_val(pe_word, 16'h0000);
        bus_write(PLL_DIV_CTRL_ADDR, 16'hC0C0);
        @(posedge clk);
        #1 cmp_val(pe_word, 16'h0000);
        bus_write(PLL_DIV_CTRL_ADDR, 16'h8585);
        @(posedge clk);
        #1 s = pe_word;
        repeat (200) @(posedge clk);
        #1 cmp_val(pe_word, s);
        bus_read(PLL_STATUS_ADDR, d);
        cmp_val({4'h0, d[15:4]}, 16'h0000);
        $display("test force done");
    endtask

    task automatic test_lock();
        logic [DATA_W-1:0] w [3] = '{16'h0307, 16'h0001, 16'h0203};
        int r;
        int v;
        bus_write(PLL_DIV_CTRL_ADDR, 16'hC182);
        @(posedge clk);
        #1 cmp_val(pe_word, 16'h0000);
        repeat (500) @(posedge clk);
        bus_write(PLL_DIV_CTRL_ADDR, 16'hC387);
        foreach (w[i]) begin
            bus_write(PLL_DIV_CTRL_ADDR, w[i]);
            r = w[i][5:0] + 1;
            v = w[i][13:8] + 1;
            repeat (6000) @(posedge clk);
            window(6000);
            cmp_rate(dn[1] * r, dn[2] * v - dn[2] * v / 50 - 16,
                     dn[2] * v + dn[2] * v / 50 + 16);
        end
        $display("test lock done");
    endtask

    task automatic test_sources();
        int src;
        for (int sel = 0; sel < 4; sel++) begin
            for (int dv = 0; dv < 8; dv++) begin
                bus_write(VIDEO_CTRL_ADDR, {10'h0, sel[0], dv[2:0], sel[1:0]});
                repeat (20) @(posedge clk);
                window(800);
                src = (sel == 0) ? dn[0] : (sel == 1) ? dn[1] : dn[2];
                cmp_rate(dn[4], src / (dv + 1) - 1,
                         src / (dv + 1) + 1);
                src = sel[0] ? dn[3] : dn[2];
                cmp_rate(dn[5], src / 2 - 1, src / 2 + 1);
                cmp_rate(dn[6], dn[2] - 1, dn[2] + 1);
            end
        end
        $display("test sources done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        cmp_val({15'h0, phase_error_oe_n}, 16'h0001);
        nrst <= 1'b1;
        test_regs();
        test_force();
        test_lock();
        test_sources();
        report_and_stop();
    end
endmodule // tb_pixel_clock_pll_control
